// [hdl/tip_pkg.sv]
// Package of constants, register map and enums for the trigger and inhibit pin block
package tip_pkg;
   localparam int          CLK_MHZ        = 125;
   localparam int          PULSE_MIN_US   = 30;
   localparam int          PULSE_MIN_CYC  = PULSE_MIN_US * CLK_MHZ;
   // Register byte offsets
   localparam logic [11:0] TRIG_CFG_OFS   = 12'h000;
   localparam logic [11:0] INH_CFG_OFS    = 12'h004;
   localparam logic [11:0] CTRL_OFS       = 12'h008;
   localparam logic [11:0] STATUS_OFS     = 12'h00C;
   localparam logic [11:0] PWM_PER_OFS    = 12'h010;
   localparam logic [11:0] PWM_DUTY_OFS   = 12'h014;
   localparam logic [11:0] MIN_LOW_OFS    = 12'h018;
   // Config fields: [0] invert, [2:1] function, [3] inhibit variant, [5:4] output value
   localparam int          CFG_INV_BIT    = 0;
   localparam int          CFG_FUNC_LSB   = 1;
   localparam int          CFG_LATCH_BIT  = 3;
   localparam int          CFG_VAL_LSB    = 4;
   // Control fields: [0] turn on, [1] turn off, [2] panel trigger, [3] clear protection, [4] source ext
   localparam int          CTL_ON_BIT     = 0;
   localparam int          CTL_OFF_BIT    = 1;
   localparam int          CTL_TRIG_BIT   = 2;
   localparam int          CTL_CLR_BIT    = 3;
   localparam int          CTL_SRC_BIT    = 4;
   localparam logic [1:0]  FUNC_SPECIAL   = 2'h0;
   localparam logic [1:0]  FUNC_INPUT     = 2'h1;
   localparam logic [1:0]  FUNC_OUTPUT    = 2'h2;
   localparam logic [1:0]  TFUNC_TRIG_IN  = 2'h3;
   localparam logic [1:0]  VAL_TRUE       = 2'h0;
   localparam logic [1:0]  VAL_FALSE      = 2'h1;
   localparam logic [1:0]  VAL_PWM        = 2'h2;
   localparam logic [31:0] TRIG_CFG_RST   = 32'h0000_0000;
   localparam logic [31:0] INH_CFG_RST    = 32'h0000_0000;
   localparam logic [31:0] PWM_PER_RST    = 32'h0000_03E8;
   localparam logic [31:0] PWM_DUTY_RST   = 32'h0000_01F4;
   localparam logic [31:0] MIN_LOW_RST    = 32'(PULSE_MIN_CYC);
   typedef enum logic [1:0] {TIP_IDLE, TIP_LOW, TIP_WAIT_HIGH} tip_det_e;
endpackage : tip_pkg

// [hdl/tip_pulse_det.sv]
// Synchronised pin input with minimum-low-width pulse detector
`timescale 1ns/1ps
`default_nettype none
module tip_pulse_det
   import tip_pkg::*;
#(
   parameter int CW = 32
) (
   input  wire logic          pclk,       // Bus clock
   input  wire logic          presetn,    // Async reset, active low
   input  wire logic          pin_in,     // Raw pin level
   input  wire logic          invert,     // Polarity inversion
   input  wire logic [CW-1:0] min_low,    // Minimum active-low cycles
   output logic               level,      // Synchronised, polarity-corrected level
   output logic               pulse       // One cycle per accepted pulse
);
   logic          sync1;
   logic          sync2;
   logic [CW-1:0] cnt;
   tip_det_e      st;

   // Two-flop synchroniser; only sync2 is read by logic
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1 <= 1'b1;
         sync2 <= 1'b1;
      end else begin
         sync1 <= pin_in;
         sync2 <= sync1;
      end
   end

   assign level = sync2 ^ invert;

   // Pulse accepted once low has lasted min_low cycles; fires once per low phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st    <= TIP_IDLE;
         cnt   <= '0;
         pulse <= 1'b0;
      end else begin
         pulse <= 1'b0;
         case (st)
            TIP_IDLE: begin
               cnt <= CW'(1);
               if (!level) st <= TIP_LOW;
            end
            TIP_LOW: begin
               if (level) begin
                  st <= TIP_IDLE;
               end else if (cnt >= min_low - CW'(1)) begin
                  pulse <= 1'b1;
                  st    <= TIP_WAIT_HIGH;
               end else begin
                  cnt <= cnt + CW'(1);
               end
            end
            TIP_WAIT_HIGH: begin
               if (level) st <= TIP_IDLE;
            end
            default: st <= TIP_IDLE;
         endcase
      end
   end
endmodule : tip_pulse_det
`default_nettype wire

// [hdl/tip_io_pins.sv]
// Trigger and inhibit pin logic with APB register access
`timescale 1ns/1ps
`default_nettype none
module tip_io_pins
   import tip_pkg::*;
#(
   parameter int CW = 32
) (
   input  wire logic        pclk,                        // Bus clock, 125 MHz
   input  wire logic        presetn,                     // Async reset, active low
   input  wire logic        psel,                        // APB select
   input  wire logic        penable,                     // APB enable
   input  wire logic        pwrite,                      // APB direction
   input  wire logic [11:0] paddr,                       // APB byte address
   input  wire logic [31:0] pwdata,                      // APB write data
   output logic [31:0]      prdata,                      // APB read data
   output logic             pready,                      // APB ready
   output logic             pslverr,                     // APB error
   input  wire logic        trig_pin_in,                 // Trigger pin level in
   output logic             trig_pin_out,                // Trigger pin drive value
   output logic             trig_pin_oe,                 // Trigger pin drive enable
   input  wire logic        inh_pin_in,                  // Inhibit pin level in
   output logic             inh_pin_out,                 // Inhibit pin drive value
   output logic             inh_pin_oe,                  // Inhibit pin drive enable
   output logic             seq_start,                   // Step-sequence start pulse
   output logic             output_on,                   // On/off state and its indication
   output logic             output_enable,               // Actual output allowed
   output logic             output_block_indicator,      // Level inhibit active while output on
   output logic             protection_block_indicator   // Latched inhibit status
);
   logic [31:0]   trig_cfg;
   logic [31:0]   inh_cfg;
   logic [31:0]   pwm_per;
   logic [31:0]   pwm_duty;
   logic [CW-1:0] min_low;
   logic          sequence_trigger_source;
   logic          trig_level;
   logic          trig_pulse;
   logic          inh_level;
   logic          inh_pulse;
   logic [31:0]   pwm_cnt;
   logic          pwm_wave;
   logic [CW-1:0] tout_cnt;
   logic          wr;
   logic          rd_hit;
   logic          panel_trig;
   logic          ext_trig;
   logic          on_req;
   logic          off_req;
   logic          clr_req;
   logic          trig_inv;
   logic          inh_inv;
   logic [1:0]    trig_func;
   logic [1:0]    inh_func;
   logic          inh_latch;
   logic          level_inh;

   assign trig_inv  = trig_cfg[CFG_INV_BIT];
   assign inh_inv   = inh_cfg[CFG_INV_BIT];
   assign trig_func = trig_cfg[CFG_FUNC_LSB +: 2];
   assign inh_func  = inh_cfg[CFG_FUNC_LSB +: 2];
   assign inh_latch = inh_cfg[CFG_LATCH_BIT];

   // Function of a pin's general-output value, polarity applied
   function automatic logic out_level(input logic [1:0] val, input logic inv, input logic pwm);
      logic v;
      case (val)
         VAL_TRUE:  v = 1'b0;   // True is low when straight
         VAL_FALSE: v = 1'b1;   // False is high when straight
         VAL_PWM:   v = pwm;
         default:   v = 1'b1;
      endcase
      return v ^ inv;
   endfunction : out_level

   // APB: zero wait states, unmapped addresses answer with an error
   assign wr      = psel & penable & pwrite;
   assign pready  = 1'b1;
   always_comb begin
      case (paddr)
         TRIG_CFG_OFS, INH_CFG_OFS, CTRL_OFS, STATUS_OFS,
         PWM_PER_OFS, PWM_DUTY_OFS, MIN_LOW_OFS: rd_hit = 1'b1;
         default:                                rd_hit = 1'b0;
      endcase
   end
   assign pslverr = psel & penable & ~rd_hit;

   // Configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_cfg                <= TRIG_CFG_RST;
         inh_cfg                 <= INH_CFG_RST;  // Inhibit, level-following
         pwm_per                 <= PWM_PER_RST;
         pwm_duty                <= PWM_DUTY_RST;
         min_low                 <= CW'(MIN_LOW_RST);
         sequence_trigger_source <= 1'b0;
      end else if (wr) begin
         case (paddr)
            TRIG_CFG_OFS: trig_cfg <= {26'h0, pwdata[5:0]};
            INH_CFG_OFS:  inh_cfg  <= {26'h0, pwdata[5:0]};
            CTRL_OFS:     sequence_trigger_source <= pwdata[CTL_SRC_BIT];
            PWM_PER_OFS:  pwm_per  <= pwdata;
            PWM_DUTY_OFS: pwm_duty <= pwdata;
            MIN_LOW_OFS:  min_low  <= CW'(pwdata);
            default: ;
         endcase
      end
   end

   // Command strobes from control writes; these bits are self-clearing
   assign on_req     = wr && paddr == CTRL_OFS && pwdata[CTL_ON_BIT];
   assign off_req    = wr && paddr == CTRL_OFS && pwdata[CTL_OFF_BIT];
   assign clr_req    = wr && paddr == CTRL_OFS && pwdata[CTL_CLR_BIT];
   assign panel_trig = wr && paddr == CTRL_OFS && pwdata[CTL_TRIG_BIT];

   // Read mux; status shows synced pin levels and the on/inhibit state
   always_comb begin
      case (paddr)
         TRIG_CFG_OFS: prdata = trig_cfg;
         INH_CFG_OFS:  prdata = inh_cfg;
         CTRL_OFS:     prdata = {27'h0, sequence_trigger_source, 4'h0};
         STATUS_OFS:   prdata = {27'h0, protection_block_indicator, output_block_indicator,
                                 output_on, inh_level, trig_level};
         PWM_PER_OFS:  prdata = pwm_per;
         PWM_DUTY_OFS: prdata = pwm_duty;
         MIN_LOW_OFS:  prdata = 32'(min_low);
         default:      prdata = 32'h0000_0000;
      endcase
   end

   // Pin receivers: synchronised, polarity-corrected, pulse-qualified
   tip_pulse_det #(.CW(CW)) u_trig_det (
      .pclk    (pclk),
      .presetn (presetn),
      .pin_in  (trig_pin_in),
      .invert  (trig_inv),
      .min_low (min_low),
      .level   (trig_level),
      .pulse   (trig_pulse)
   );
   tip_pulse_det #(.CW(CW)) u_inh_det (
      .pclk    (pclk),
      .presetn (presetn),
      .pin_in  (inh_pin_in),
      .invert  (inh_inv),
      .min_low (min_low),
      .level   (inh_level),
      .pulse   (inh_pulse)
   );

   // Shared PWM: period count and high-time count programmed apart
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_cnt <= 32'h0000_0000;
      end else if (pwm_cnt + 32'h0000_0001 >= pwm_per) begin
         pwm_cnt <= 32'h0000_0000;
      end else begin
         pwm_cnt <= pwm_cnt + 32'h0000_0001;
      end
   end
   assign pwm_wave = pwm_cnt < pwm_duty;

   // Sequence start: panel trigger under manual source, pin pulse under external
   assign ext_trig  = trig_func == TFUNC_TRIG_IN && sequence_trigger_source && trig_pulse;
   assign seq_start = (panel_trig && !sequence_trigger_source) || ext_trig;

   // Trigger-out low-time counter, restarted by each run start while the trigger pin is in special function
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tout_cnt <= '0;
      end else if (seq_start && trig_func == FUNC_SPECIAL) begin
         tout_cnt <= CW'(PULSE_MIN_CYC);
      end else if (tout_cnt != '0) begin
         tout_cnt <= tout_cnt - CW'(1);
      end
   end

   // Trigger pin drive
   always_comb begin
      trig_pin_oe  = 1'b0;
      trig_pin_out = 1'b1;
      case (trig_func)
         FUNC_SPECIAL: begin
            trig_pin_oe  = 1'b1;
            trig_pin_out = (tout_cnt == '0) ^ trig_inv;
         end
         FUNC_OUTPUT: begin
            trig_pin_oe  = 1'b1;
            trig_pin_out = out_level(trig_cfg[CFG_VAL_LSB +: 2], trig_inv, pwm_wave);
         end
         default: ;  // Inputs leave the pin undriven
      endcase
   end

   // Inhibit pin drive, only in general-output mode
   always_comb begin
      inh_pin_oe  = inh_func == FUNC_OUTPUT;
      inh_pin_out = inh_pin_oe ? out_level(inh_cfg[CFG_VAL_LSB +: 2], inh_inv, pwm_wave) : 1'b1;
   end

   // Level inhibit: active-low after polarity; open pin reads high
   assign level_inh = inh_func == FUNC_SPECIAL && !inh_latch && !inh_level;
   assign output_block_indicator = level_inh && output_on;
   assign output_enable = output_on && !level_inh;

   // On state and latched protection; the pulse wins over a same-cycle clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         output_on                  <= 1'b0;
         protection_block_indicator <= 1'b0;
      end else begin
         if (inh_func == FUNC_SPECIAL && inh_latch && inh_pulse && output_on) begin
            output_on                  <= 1'b0;  // Open non-inverted pin never pulses
            protection_block_indicator <= 1'b1;
         end else begin
            if (clr_req) protection_block_indicator <= 1'b0;
            if (off_req) output_on <= 1'b0;
            else if (on_req && !protection_block_indicator) output_on <= 1'b1;
         end
      end
   end

   // Checks
   latch_turnoff_a: assert property (@(posedge pclk) disable iff (!presetn)
      inh_func == FUNC_SPECIAL && inh_latch && inh_pulse && output_on
      |=> !output_on && protection_block_indicator) else $error("latch inhibit missed");
   no_auto_on_a: assert property (@(posedge pclk) disable iff (!presetn)
      !output_on && !on_req |=> !output_on) else $error("output turned on by itself");
   prot_block_a: assert property (@(posedge pclk) disable iff (!presetn)
      protection_block_indicator && !clr_req |=> !$rose(output_on)) else $error("on while protected");
   level_force_a: assert property (@(posedge pclk) disable iff (!presetn)
      level_inh |-> !output_enable) else $error("inhibit did not force zero");
   level_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
      output_on && $fell(level_inh) && !off_req |-> output_enable) else $error("no recovery");
   trig_width_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(tout_cnt != '0) |-> (tout_cnt != '0)[*8]) else $error("trigger pulse short");
   trig_count_a: assert property (@(posedge pclk) disable iff (!presetn)
      tout_cnt != '0 && !(seq_start && trig_func == FUNC_SPECIAL)
      |=> tout_cnt == $past(tout_cnt) - CW'(1)) else $error("trigger count skipped");
   ext_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      ext_trig |-> seq_start) else $error("external start lost");
   manual_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      panel_trig && !sequence_trigger_source && trig_func == FUNC_SPECIAL
      |=> tout_cnt == CW'(PULSE_MIN_CYC)) else $error("manual start no pulse");
   true_level_a: assert property (@(posedge pclk) disable iff (!presetn)
      inh_func == FUNC_OUTPUT && inh_cfg[CFG_VAL_LSB +: 2] == VAL_TRUE
      |-> inh_pin_out == inh_inv) else $error("true level wrong");
   false_level_a: assert property (@(posedge pclk) disable iff (!presetn)
      inh_func == FUNC_OUTPUT && inh_cfg[CFG_VAL_LSB +: 2] == VAL_FALSE
      |-> inh_pin_out == !inh_inv) else $error("false level wrong");
   latch_cov_c: cover property (@(posedge pclk) inh_pulse && inh_latch && output_on);
   level_cov_c: cover property (@(posedge pclk) output_block_indicator);
   start_cov_c: cover property (@(posedge pclk) ext_trig);
   pwm_cov_c:   cover property (@(posedge pclk) inh_pin_oe && $rose(pwm_wave));
endmodule : tip_io_pins
`default_nettype wire

// [testbench/tip_pin_partner.sv]
// Far-side model: external controller on the trigger and inhibit pins
`timescale 1ns/1ps
`default_nettype none
module tip_pin_partner (
   input  wire logic pclk,         // Bus clock
   input  wire logic trig_pin_out, // Device trigger drive value
   input  wire logic trig_pin_oe,  // Device trigger drive enable
   input  wire logic inh_pin_out,  // Device inhibit drive value
   input  wire logic inh_pin_oe,   // Device inhibit drive enable
   output logic      trig_pin_in,  // Resolved trigger wire
   output logic      inh_pin_in    // Resolved inhibit wire
);
   logic [1:0] drv_en  = 2'h0;
   logic [1:0] drv_val = 2'h3;
   // Pull-up on both wires: an open pin reads high
   assign trig_pin_in = trig_pin_oe ? trig_pin_out : (drv_en[0] ? drv_val[0] : 1'b1);
   assign inh_pin_in  = inh_pin_oe ? inh_pin_out : (drv_en[1] ? drv_val[1] : 1'b1);
   // Drive one pin to a level after a rising edge
   task automatic drive(input int p, input logic lvl);
      @(posedge pclk);
      drv_en[p]  <= 1'b1;
      drv_val[p] <= lvl;
   endtask : drive
   // Let go of a pin so the pull-up takes over
   task automatic free(input int p);
      @(posedge pclk);
      drv_en[p] <= 1'b0;
   endtask : free
   // Low pulse held for n+1 cycles; callers use it both above and below the set minimum
   task automatic pulse(input int p, input int n);
      drive(p, 1'b0);
      repeat (n) @(posedge pclk);
      free(p);
   endtask : pulse
endmodule : tip_pin_partner
`default_nettype wire

// [testbench/tb_tip_io_pins.sv]
// Self-checking bench for the trigger and inhibit pin block
`timescale 1ns/1ps
`default_nettype none
module tb_tip_io_pins;
   import tip_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, err, seq_start, output_on, output_enable;
   logic        trig_pin_in, trig_pin_out, trig_pin_oe, inh_pin_in, inh_pin_out, inh_pin_oe;
   logic        output_block_indicator, protection_block_indicator;
   int          num_errors = 0;
   int          n_checks = 0;
   int          n_starts = 0;
   int          i, p, v, s, cnt;
   logic [11:0] rst_a [5] = '{TRIG_CFG_OFS, INH_CFG_OFS, PWM_PER_OFS, PWM_DUTY_OFS, MIN_LOW_OFS};
   logic [31:0] rst_v [5] = '{TRIG_CFG_RST, INH_CFG_RST, PWM_PER_RST, PWM_DUTY_RST, MIN_LOW_RST};

   always #4 pclk = ~pclk;
   // Count sequence starts so no single-cycle pulse is missed
   always @(posedge pclk) begin
      if (seq_start === 1'b1) n_starts <= n_starts + 1;
   end

   tip_io_pins i_tip_io_pins (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .trig_pin_in(trig_pin_in), .trig_pin_out(trig_pin_out),
      .trig_pin_oe(trig_pin_oe), .inh_pin_in(inh_pin_in), .inh_pin_out(inh_pin_out),
      .inh_pin_oe(inh_pin_oe), .seq_start(seq_start), .output_on(output_on),
      .output_enable(output_enable), .output_block_indicator(output_block_indicator),
      .protection_block_indicator(protection_block_indicator));
   tip_pin_partner i_tip_pin_partner (.pclk(pclk), .trig_pin_out(trig_pin_out),
      .trig_pin_oe(trig_pin_oe), .inh_pin_out(inh_pin_out), .inh_pin_oe(inh_pin_oe),
      .trig_pin_in(trig_pin_in), .inh_pin_in(inh_pin_in));

   // Config word: value, variant, function, invert
   function automatic logic [31:0] cfg(input logic [1:0] val, input logic [1:0] fn,
                                       input logic lat, input logic inv);
      return 32'({val, lat, fn, inv});
   endfunction : cfg
   task automatic give_verdict;
      $display("Checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // One APB transfer; request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (k == 20) begin
         num_errors++;
         $display("Error apb_wait expected 1 seen 0");
         give_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Watchdog against any hang
   initial begin
      repeat (100000) @(posedge pclk);
      num_errors++;
      $display("Error watchdog expected 0 seen 1");
      give_verdict();
   end

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values, idle trigger drive, unmapped access
      chk("trig_idle", {trig_pin_oe, trig_pin_out, inh_pin_oe}, 3'h6);
      for (i = 0; i < 5; i++) begin
         apb(1'b0, rst_a[i], 32'h0);
         chk("reset_value", rd, rst_v[i]);
      end
      apb(1'b0, 12'h01C, 32'h0);
      chk("unmapped_err", err, 1'b1);
      chk("unmapped_data", rd, 32'h0);
      // Shorter minimum keeps the run brief
      apb(1'b1, MIN_LOW_OFS, 32'h8);
      // Panel trigger with manual source: one start, low pulse of full width
      s = n_starts;
      apb(1'b1, CTRL_OFS, 32'h1 << CTL_TRIG_BIT);
      for (i = 0; i < 10 && trig_pin_out !== 1'b0; i++) @(posedge pclk);
      cnt = 0;
      for (i = 0; i < 5000 && trig_pin_out === 1'b0; i++) begin
         @(posedge pclk);
         cnt++;
      end
      chk("trig_low_cycles", cnt, PULSE_MIN_CYC);
      chk("manual_start", n_starts - s, 1);
      // External trigger: valid pulse starts, short pulse refused
      apb(1'b1, TRIG_CFG_OFS, cfg(2'h0, TFUNC_TRIG_IN, 1'b0, 1'b0));
      apb(1'b1, CTRL_OFS, 32'h1 << CTL_SRC_BIT);
      s = n_starts;
      i_tip_pin_partner.pulse(0, 12);
      repeat (6) @(posedge pclk);
      chk("ext_start", n_starts - s, 1);
      i_tip_pin_partner.pulse(0, 4);
      repeat (6) @(posedge pclk);
      chk("short_refused", n_starts - s, 1);
      // General input on both pins, both polarities
      for (p = 0; p < 2; p++) begin
         for (v = 0; v < 4; v++) begin
            apb(1'b1, p ? INH_CFG_OFS : TRIG_CFG_OFS, cfg(2'h0, FUNC_INPUT, 1'b0, v[1]));
            i_tip_pin_partner.drive(p, v[0]);
            repeat (4) @(posedge pclk);
            apb(1'b0, STATUS_OFS, 32'h0);
            chk("input_level", rd[p], v[0] ^ v[1]);
         end
         i_tip_pin_partner.free(p);
      end
      // Level-following inhibit
      apb(1'b1, INH_CFG_OFS, cfg(2'h0, FUNC_SPECIAL, 1'b0, 1'b0));
      apb(1'b1, CTRL_OFS, 32'h1 << CTL_ON_BIT);
      repeat (4) @(posedge pclk);
      chk("open_pin", {output_on, output_enable, output_block_indicator}, 3'h6);
      i_tip_pin_partner.drive(1, 1'b0);
      repeat (4) @(posedge pclk);
      chk("level_block", {output_on, output_enable, output_block_indicator}, 3'h5);
      i_tip_pin_partner.free(1);
      repeat (4) @(posedge pclk);
      chk("level_restore", {output_on, output_enable, output_block_indicator}, 3'h6);
      apb(1'b1, INH_CFG_OFS, cfg(2'h0, FUNC_SPECIAL, 1'b0, 1'b1));
      repeat (4) @(posedge pclk);
      chk("inv_high_blocks", output_enable, 1'b0);
      i_tip_pin_partner.drive(1, 1'b0);
      repeat (4) @(posedge pclk);
      chk("inv_low_passes", output_enable, 1'b1);
      i_tip_pin_partner.free(1);
      // Latching inhibit: pulse turns off, protection holds until cleared
      apb(1'b1, INH_CFG_OFS, cfg(2'h0, FUNC_SPECIAL, 1'b1, 1'b0));
      repeat (4) @(posedge pclk);
      chk("latch_open", {output_on, protection_block_indicator}, 2'h2);
      i_tip_pin_partner.pulse(1, 12);
      repeat (6) @(posedge pclk);
      chk("latch_off", {output_on, protection_block_indicator}, 2'h1);
      apb(1'b1, CTRL_OFS, 32'h1 << CTL_ON_BIT);
      repeat (4) @(posedge pclk);
      chk("stays_off", output_on, 1'b0);
      apb(1'b1, CTRL_OFS, 32'h1 << CTL_CLR_BIT);
      apb(1'b1, CTRL_OFS, 32'h1 << CTL_ON_BIT);
      repeat (2) @(posedge pclk);
      chk("on_after_clear", {output_on, protection_block_indicator}, 2'h2);
      apb(1'b1, CTRL_OFS, 32'h1 << CTL_OFF_BIT);
      repeat (2) @(posedge pclk);
      chk("turned_off", output_on, 1'b0);
      apb(1'b1, CTRL_OFS, 32'h1 << CTL_ON_BIT);
      repeat (2) @(posedge pclk);
      chk("on_again", output_on, 1'b1);
      // General output, true and false, both polarities, both pins
      for (p = 0; p < 2; p++) begin
         for (v = 0; v < 4; v++) begin
            apb(1'b1, p ? INH_CFG_OFS : TRIG_CFG_OFS,
                cfg(v[0] ? VAL_FALSE : VAL_TRUE, FUNC_OUTPUT, 1'b0, v[1]));
            repeat (2) @(posedge pclk);
            chk("out_oe", p ? inh_pin_oe : trig_pin_oe, 1'b1);
            chk("out_level", p ? inh_pin_out : trig_pin_out, v[0] ^ v[1]);
         end
      end
      // PWM: high time per period follows the duty setting
      apb(1'b1, PWM_PER_OFS, 32'hA);
      for (v = 3; v < 6; v += 2) begin
         apb(1'b1, PWM_DUTY_OFS, 32'(v));
         apb(1'b1, INH_CFG_OFS, cfg(VAL_PWM, FUNC_OUTPUT, 1'b0, 1'b0));
         repeat (12) @(posedge pclk);
         cnt = 0;
         for (i = 0; i < 10; i++) begin
            @(posedge pclk);
            if (inh_pin_out === 1'b1) cnt++;
         end
         chk("pwm_high", cnt, v);
      end
      give_verdict();
   end
endmodule : tb_tip_io_pins
`default_nettype wire
